// file: verilog/host_port_and_dma_master.sv
// Host port, maintenance logic, ALU move path and DMA bus master
// Functional notes
// - Move-from-branch uses branch register and scratch
// - Destination scratch or branch overwritten by result
// - Register RAM shared; maintenance byte fixed
// - Select then write bit stores control word
// - Select makes data word read control store
// - 0x40 master clears; 0x80 runs from zero
// - Request, acknowledge, data, clear handshake
// - Microcode rereads transfer type bits
// - Single bits race free; no shared byte
// - Byte and direction bits select transfer
// - Byte to low lane when address even
// - Byte to high lane when address odd
// - DMA request self clears at completion
// - Hold bit keeps mastership between transfers
// - Clearing hold drops acknowledge, and releases on the same edge if no request is set
// - Hold cleared when idle releases at once
`include "host_port_regs.svh"
`default_nettype none
module host_port_and_dma_master (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Avalon-MM slave
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Microsequencer move path
    input wire logic mc_move_i,
    input wire logic [2:0] mc_dest_i,
    input wire logic [3:0] mc_scratch_addr_i,
    input wire logic [3:0] mc_alu_fn_i,
    // Host bus master
    output logic bus_req_o,
    output logic selection_acknowledge_o,
    output logic bus_master_o,
    output logic bus_write_o,
    output logic [17:0] bus_addr_o,
    output logic [15:0] bus_wdata_o,
    output logic [1:0] bus_be_o,
    input wire logic bus_grant_i,
    input wire logic bus_done_i,
    input wire logic [15:0] bus_rdata_i,
    // Processor state
    output logic run_o,
    output logic master_clear_o,
    output logic [9:0] pc_o
);
    import host_port_pkg::*;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [15:0] mnt_reg;
    logic [15:0] dma_ctl_reg;
    logic [15:0] misc_reg;
    logic [15:0] out_data_reg;
    logic [17:0] out_ba_reg;
    logic [17:0] in_ba_reg;
    logic [15:0] in_data_reg;
    logic [7:0] branch_register_reg;
    logic [7:0] scratch_pad_reg [0:15];
    logic [9:0] pc_reg;
    logic [31:0] rdata_reg;
    logic ack_reg;
    logic rd_pend_reg;
    logic sel_ack_reg;
    logic master_reg;
    logic req_reg;
    logic wait_reg;
    dma_state_type dma_state_reg;
    dma_state_type dma_state_next;

    csr_bus_if csr();
    logic [15:0] cs_rdata;

    csr_ram u_csr (
        .clock_i(clock_i),
        .bus(csr.ram)
    );

    // ------------------------------------------------------------
    // Host decode
    // ------------------------------------------------------------
    wire acc = (avs_read_i || avs_write_i) && !ack_reg;
    wire wr = avs_write_i && !ack_reg;
    wire in_csr = avs_address_i[3:2] == 2'b00;
    wire hit_mnt_hi = wr && avs_address_i == `HP_SEL0_ADDR
        && avs_byteenable_i[1];
    wire [7:0] mnt_byte = avs_writedata_i[15:8];
    wire cmd_mclr = hit_mnt_hi && mnt_byte == `HP_MNT_CMD_MCLR;
    wire cmd_run = hit_mnt_hi && mnt_byte == `HP_MNT_CMD_RUN;
    wire cs_sel = mnt_reg[`HP_MNT_CS_SEL];
    logic [7:0] alu_out;
    logic [9:0] mnt_addr_reg;
    logic [15:0] mnt_data_reg;
    // Write happens when write bit rises while select is held
    wire cs_write = hit_mnt_hi && cs_sel
        && mnt_byte[`HP_MNT_CS_WRITE-8]
        && !mnt_reg[`HP_MNT_CS_WRITE];
    wire mclr = mnt_reg[`HP_MNT_MCLR];
    wire is_sel6 = avs_address_i == `HP_SEL6_ADDR;

    // Control store reached only while select is set
    control_store u_cs (
        .clock_i(clock_i),
        .addr_i(mnt_addr_reg),
        .wdata_i(mnt_data_reg),
        .we_i(cs_write),
        .rdata_o(cs_rdata)
    );

    // Host side of the shared RAM; microcode side via move path
    assign csr.host_addr = avs_address_i[1:0];
    assign csr.host_wdata = avs_writedata_i[15:0];
    assign csr.host_be = (avs_address_i == `HP_SEL0_ADDR) ?
        {1'b0, avs_byteenable_i[0]} : avs_byteenable_i[1:0];
    assign csr.host_we = wr && in_csr;
    assign csr.mc_addr = mc_scratch_addr_i[1:0];
    assign csr.mc_wdata = {alu_out, alu_out};
    assign csr.mc_be = mc_scratch_addr_i[2] ? 2'b10 : 2'b01;
    // Single-byte microcode writes only; host byte wins a clash
    assign csr.mc_we = mc_move_i && mc_dest_i == 3'h4 && run_o;

    // ------------------------------------------------------------
    // Maintenance, run and program counter
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            mnt_reg <= `HP_ZERO16;
            pc_reg <= 10'h000;
            mnt_addr_reg <= 10'h000;
            mnt_data_reg <= `HP_ZERO16;
        end else begin
            if (hit_mnt_hi) begin
                mnt_reg[15:8] <= mnt_byte;
            end
            if (wr && avs_address_i == `HP_SEL4_ADDR) begin
                mnt_addr_reg <= avs_writedata_i[9:0];
            end
            if (wr && is_sel6) begin
                mnt_data_reg <= avs_writedata_i[15:0];
            end
            if (cmd_mclr || mclr) begin
                pc_reg <= 10'h000;
            end else if (cmd_run) begin
                pc_reg <= 10'h000;
            end else if (mnt_reg[`HP_MNT_RUN]) begin
                pc_reg <= pc_reg + 10'h001;
            end
        end
    end

    // ------------------------------------------------------------
    // Avalon slave: two wait cycles on reads for registered read data
    // ------------------------------------------------------------
    logic [31:0] rmux;
    always_comb begin
        rmux = 32'h0000_0000;
        case (avs_address_i)
            `HP_SEL0_ADDR: rmux = {16'h0000, mnt_reg[15:8],
                csr.host_rdata[7:0]};
            `HP_SEL4_ADDR: rmux = {22'h000000, mnt_addr_reg};
            `HP_SEL6_ADDR: rmux = cs_sel ? {16'h0000, cs_rdata}
                : {16'h0000, mnt_data_reg};
            `HP_SEL2_ADDR: rmux = {16'h0000, csr.host_rdata};
            `HP_DMACTL_ADDR: rmux = {16'h0000, dma_ctl_reg};
            `HP_MISC_ADDR: rmux = {16'h0000, misc_reg};
            `HP_OUTDATA_ADDR: rmux = {16'h0000, out_data_reg};
            `HP_OUTBA_ADDR: rmux = {14'h0000, out_ba_reg};
            `HP_INBA_ADDR: rmux = {14'h0000, in_ba_reg};
            `HP_INDATA_ADDR: rmux = {16'h0000, in_data_reg};
            `HP_USTAT_ADDR: rmux = {20'h00000, dma_state_reg,
                master_reg, sel_ack_reg, pc_reg[7:0]};
            default: rmux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            wait_reg <= 1'b1;
            rd_pend_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            rd_pend_reg <= avs_read_i && !ack_reg && !rd_pend_reg;
            ack_reg <= acc && (avs_write_i || rd_pend_reg);
            wait_reg <= !(acc && (avs_write_i || rd_pend_reg));
            if (rd_pend_reg) begin
                rdata_reg <= rmux;
            end
        end
    end
    assign avs_readdata_o = rdata_reg;
    assign avs_waitrequest_o = wait_reg;

    // ------------------------------------------------------------
    // ALU move path: branch register source
    // ------------------------------------------------------------
    wire [7:0] scr_a = scratch_pad_reg[mc_scratch_addr_i];
    wire [7:0] b_opd = branch_register_reg;
    always_comb begin
        case (mc_alu_fn_i)
            4'h0: alu_out = scr_a + b_opd;
            4'h2: alu_out = scr_a + 8'h01;
            4'h5: alu_out = scr_a << 1;
            4'h8: alu_out = scr_a - 8'h01;
            4'h9: alu_out = scr_a;
            4'ha: alu_out = b_opd;
            4'hb: alu_out = scr_a | b_opd;
            4'hc: alu_out = scr_a & b_opd;
            4'hd: alu_out = scr_a ^ b_opd;
            4'he: alu_out = scr_a - b_opd;
            default: alu_out = b_opd;
        endcase
    end
    wire dest_scratch = mc_move_i
        && (mc_dest_i == 3'h6 || mc_dest_i == 3'h7);
    wire dest_br = mc_move_i && (mc_dest_i == 3'h7 || mc_dest_i == 3'h0);
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            branch_register_reg <= 8'h00;
        end else if (dest_br) begin
            branch_register_reg <= alu_out;
        end
    end
    always_ff @(posedge clock_i) begin
        if (dest_scratch) begin
            scratch_pad_reg[mc_scratch_addr_i] <= alu_out;
        end
    end

    // ------------------------------------------------------------
    // DMA control registers (host view stands in for microcode OUT)
    // ------------------------------------------------------------
    wire dma_ctl_wr = wr && avs_address_i == `HP_DMACTL_ADDR;
    wire req_bit = dma_ctl_reg[`HP_DMA_REQ];
    wire hold_bit = dma_ctl_reg[`HP_DMA_HOLD];
    wire dma_end = dma_state_reg == dma_done_type;
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            dma_ctl_reg <= `HP_ZERO16;
            misc_reg <= `HP_ZERO16;
            out_data_reg <= `HP_ZERO16;
            out_ba_reg <= 18'h00000;
            in_ba_reg <= 18'h00000;
        end else if (mclr) begin
            dma_ctl_reg[`HP_DMA_HOLD:`HP_DMA_REQ] <= 2'b00;
            misc_reg[`HP_MISC_IRQ] <= 1'b0;
        end else begin
            if (dma_ctl_wr) begin
                dma_ctl_reg <= avs_writedata_i[15:0];
            end else if (dma_end) begin
                dma_ctl_reg[`HP_DMA_REQ] <= 1'b0;
            end
            if (wr && avs_address_i == `HP_MISC_ADDR) begin
                misc_reg <= avs_writedata_i[15:0];
            end
            if (wr && avs_address_i == `HP_OUTDATA_ADDR) begin
                out_data_reg <= avs_writedata_i[15:0];
            end
            if (wr && avs_address_i == `HP_OUTBA_ADDR) begin
                out_ba_reg <= avs_writedata_i[17:0];
            end
            if (wr && avs_address_i == `HP_INBA_ADDR) begin
                in_ba_reg <= avs_writedata_i[17:0];
            end
        end
    end

    // ------------------------------------------------------------
    // DMA sequencer
    // ------------------------------------------------------------
    wire [1:0] code = {dma_ctl_reg[`HP_DMA_BYTE], dma_ctl_reg[`HP_DMA_OUT]};
    wire is_read = code == 2'b00;
    wire is_byte = code == 2'b11;
    wire [17:0] tgt = is_read ? in_ba_reg : out_ba_reg;
    wire odd = tgt[0];
    wire [15:0] wdata_sel = is_byte ? {out_data_reg[7:0], out_data_reg[7:0]}
        : out_data_reg;
    wire [1:0] be_sel = !is_byte ? 2'b11 : (odd ? 2'b10 : 2'b01);
    wire start = req_bit && code != 2'b10 && (master_reg || bus_grant_i);

    always_comb begin
        dma_state_next = dma_state_reg;
        case (dma_state_reg)
            dma_idle_type: if (start) dma_state_next = dma_busy_type;
            dma_busy_type: if (bus_done_i) dma_state_next = dma_done_type;
            dma_done_type: dma_state_next = dma_idle_type;
            default: dma_state_next = dma_idle_type;
        endcase
    end

    logic [15:0] in_data_next;
    assign in_data_next = (dma_state_reg == dma_busy_type && bus_done_i
        && is_read) ? bus_rdata_i : in_data_reg;
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            dma_state_reg <= dma_idle_type;
            in_data_reg <= `HP_ZERO16;
            master_reg <= 1'b0;
            sel_ack_reg <= 1'b0;
            req_reg <= 1'b0;
        end else begin
            dma_state_reg <= mclr ? dma_idle_type : dma_state_next;
            in_data_reg <= in_data_next;
            req_reg <= req_bit && !master_reg && !mclr;
            // Hold keeps mastership; dropping hold drops sack, and mastership on the same edge if no request
            if (mclr) begin
                master_reg <= 1'b0;
                sel_ack_reg <= 1'b0;
            end else if (start && !master_reg) begin
                master_reg <= 1'b1;
                sel_ack_reg <= 1'b1;
            end else begin
                sel_ack_reg <= master_reg && hold_bit;
                if (!hold_bit && !req_bit) begin
                    master_reg <= 1'b0;
                end else if (hold_bit) begin
                    master_reg <= master_reg;
                end
            end
        end
    end

    assign bus_req_o = req_reg;
    assign selection_acknowledge_o = sel_ack_reg;
    assign bus_master_o = master_reg;
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            bus_write_o <= 1'b0;
            bus_addr_o <= 18'h00000;
            bus_wdata_o <= `HP_ZERO16;
            bus_be_o <= 2'b00;
            run_o <= 1'b0;
            master_clear_o <= 1'b0;
        end else begin
            bus_write_o <= dma_state_next == dma_busy_type && !is_read;
            bus_addr_o <= {tgt[17:1], is_byte & odd};
            bus_wdata_o <= wdata_sel;
            bus_be_o <= be_sel;
            run_o <= mnt_reg[`HP_MNT_RUN] && !mclr;
            master_clear_o <= mclr;
        end
    end
    assign pc_o = pc_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_req_clears;
        @(posedge clock_i) disable iff (rst_i)
        dma_end && !dma_ctl_wr && !mclr |=> !req_bit;
    endproperty
    a_req_clears: assert property (p_req_clears)
        else $error("request bit did not self clear");
    property p_hold_keeps;
        @(posedge clock_i) disable iff (rst_i)
        master_reg && hold_bit && !mclr |=> master_reg;
    endproperty
    a_hold_keeps: assert property (p_hold_keeps)
        else $error("mastership lost while hold set");
    property p_idle_release;
        @(posedge clock_i) disable iff (rst_i)
        master_reg && !hold_bit && !req_bit && !start |=> !master_reg;
    endproperty
    a_idle_release: assert property (p_idle_release)
        else $error("bus not released when idle");
    property p_sack_drop;
        @(posedge clock_i) disable iff (rst_i)
        !hold_bit && !(start && !master_reg) |=> !sel_ack_reg;
    endproperty
    a_sack_drop: assert property (p_sack_drop)
        else $error("acknowledge held after hold cleared");
    property p_byte_hi;
        @(posedge clock_i) disable iff (rst_i)
        is_byte && odd |=> bus_be_o == 2'b10;
    endproperty
    a_byte_hi: assert property (p_byte_hi)
        else $error("odd byte not steered high");
    property p_byte_lo;
        @(posedge clock_i) disable iff (rst_i)
        is_byte && !odd |=> bus_be_o == 2'b01
            && bus_wdata_o[7:0] == $past(out_data_reg[7:0]);
    endproperty
    a_byte_lo: assert property (p_byte_lo)
        else $error("even byte not steered low");
    property p_mclr;
        @(posedge clock_i) disable iff (rst_i)
        cmd_mclr |=> ##1 pc_reg == 10'h000 && !run_o;
    endproperty
    a_mclr: assert property (p_mclr)
        else $error("master clear did not reset");
    property p_run;
        @(posedge clock_i) disable iff (rst_i)
        cmd_run |=> pc_reg == 10'h000 ##1 run_o;
    endproperty
    a_run: assert property (p_run)
        else $error("run not started from zero");
    property p_answer;
        @(posedge clock_i) disable iff (rst_i)
        avs_read_i && avs_waitrequest_o |-> ##[1:3] !avs_waitrequest_o;
    endproperty
    a_answer: assert property (p_answer)
        else $error("host read not answered");
    c_dma: cover property (@(posedge clock_i) dma_end);
    c_byte: cover property (@(posedge clock_i) dma_end && is_byte);
    c_cs_write: cover property (@(posedge clock_i) cs_write);
    c_hold: cover property (@(posedge clock_i) dma_end && hold_bit);
endmodule
`default_nettype wire

// file: verilog/host_port_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef HOST_PORT_REGS_SVH
`define HOST_PORT_REGS_SVH
// Avalon word addresses of the host-visible registers
`define HP_SEL0_ADDR 4'h0
`define HP_SEL2_ADDR 4'h1
`define HP_SEL4_ADDR 4'h2
`define HP_SEL6_ADDR 4'h3
`define HP_UCTL_ADDR 4'h4
`define HP_USTAT_ADDR 4'h5
`define HP_DMACTL_ADDR 4'h6
`define HP_MISC_ADDR 4'h7
`define HP_OUTDATA_ADDR 4'h8
`define HP_OUTBA_ADDR 4'h9
`define HP_INBA_ADDR 4'ha
`define HP_INDATA_ADDR 4'hb
// Maintenance word bits
`define HP_MNT_CS_SEL 10
`define HP_MNT_CS_WRITE 13
`define HP_MNT_MCLR 14
`define HP_MNT_RUN 15
// Maintenance byte commands
`define HP_MNT_CMD_MCLR 8'h40
`define HP_MNT_CMD_RUN 8'h80
// DMA control bits
`define HP_DMA_REQ 0
`define HP_DMA_HOLD 1
`define HP_DMA_BYTE 2
`define HP_DMA_OUT 3
// Misc register: interrupt request bit, extended address bits
`define HP_MISC_IRQ 7
`define HP_MISC_XA_LO 2
// Reset values
`define HP_ZERO16 16'h0000
// Host bus transfer time in cycles
`define HP_DMA_CYCLES 4'h3
`endif

// file: verilog/host_port_pkg.sv
// Types shared by the host port design
`default_nettype none
package host_port_pkg;
    typedef enum logic [1:0] {
        dma_idle_type, dma_busy_type, dma_done_type
    } dma_state_type;
    typedef enum logic [1:0] {
        xfer_word_read_type, xfer_word_write_type,
        xfer_unused_type, xfer_byte_write_type
    } xfer_code_type;
endpackage
`default_nettype wire

// file: verilog/csr_bus_if.sv
// Port between the shared register RAM and its owner
`default_nettype none
interface csr_bus_if;
    logic [1:0] host_addr;
    logic [15:0] host_wdata;
    logic [1:0] host_be;
    logic host_we;
    logic [1:0] mc_addr;
    logic [15:0] mc_wdata;
    logic [1:0] mc_be;
    logic mc_we;
    logic [15:0] host_rdata;
    logic [15:0] mc_rdata;
    modport owner(output host_addr, host_wdata, host_be, host_we,
        mc_addr, mc_wdata, mc_be, mc_we, input host_rdata, mc_rdata);
    modport ram(input host_addr, host_wdata, host_be, host_we,
        mc_addr, mc_wdata, mc_be, mc_we, output host_rdata, mc_rdata);
endinterface
`default_nettype wire

// file: verilog/csr_ram.sv
// Two-port register RAM shared by host and microcode, byte writable
`default_nettype none
module csr_ram (
    // Clock
    input wire logic clock_i,
    // Ports
    csr_bus_if.ram bus
);
    logic [15:0] mem [0:3];
    logic [15:0] host_rdata_reg;
    logic [15:0] mc_rdata_reg;
    logic [1:0] mc_be_eff;
    // Host write to a byte takes that byte; the sides never share a byte
    assign mc_be_eff = (bus.host_we && bus.host_addr == bus.mc_addr) ?
        (bus.mc_be & ~bus.host_be) : bus.mc_be;
    always_ff @(posedge clock_i) begin
        for (int b = 0; b < 2; b++) begin
            if (bus.host_we && bus.host_be[b]) begin
                mem[bus.host_addr][b*8 +: 8] <= bus.host_wdata[b*8 +: 8];
            end
            if (bus.mc_we && mc_be_eff[b]) begin
                mem[bus.mc_addr][b*8 +: 8] <= bus.mc_wdata[b*8 +: 8];
            end
        end
        host_rdata_reg <= mem[bus.host_addr];
        mc_rdata_reg <= mem[bus.mc_addr];
    end
    assign bus.host_rdata = host_rdata_reg;
    assign bus.mc_rdata = mc_rdata_reg;
endmodule
`default_nettype wire

// file: verilog/control_store.sv
// Writeable control store, one-port, registered read
`default_nettype none
module control_store (
    // Clock
    input wire logic clock_i,
    // Access
    input wire logic [9:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic we_i,
    output logic [15:0] rdata_o
);
    logic [15:0] mem [0:1023];
    always_ff @(posedge clock_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
        rdata_o <= mem[addr_i];
    end
endmodule
`default_nettype wire

// file: test/bus_arbiter_model.sv
// Arbiter and memory on the far side of the host bus
`default_nettype none
module bus_arbiter_model #(parameter int WAIT = 3) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // From the bus master
    input wire logic bus_req_i,
    input wire logic bus_master_i,
    input wire logic [17:0] bus_addr_i,
    // Answers
    output logic bus_grant_o,
    output logic bus_done_o,
    output logic [15:0] bus_rdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_reg;
    logic [15:0] mem_data;
    assign mem_data = bus_addr_i[15:0] ^ 16'h5a5a;
    // Released data lines show the inverse
    assign bus_rdata_o = bus_done_o ? mem_data : ~mem_data;
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            bus_grant_o <= 1'b0;
            bus_done_o <= 1'b0;
            cnt_reg <= 4'h0;
        end else begin
            bus_grant_o <= bus_req_i | (bus_grant_o & bus_master_i);
            bus_done_o <= bus_master_i && cnt_reg == 4'(WAIT);
            cnt_reg <= (bus_master_i && cnt_reg != 4'(WAIT)) ?
                cnt_reg + 4'h1 : 4'h0;
        end
    end
endmodule
`default_nettype wire

// file: test/host_port_and_dma_master_tb.sv
// Self-checking bench of the host port and DMA master
`include "host_port_regs.svh"
`default_nettype none
module host_port_and_dma_master_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i, rst_i, rd, wr, wq, req, sack, mst, bwr, grant, done;
    logic run, mclr, mv;
    logic [2:0] dst;
    logic [3:0] spa, fn;
    logic [3:0] addr, be;
    logic [31:0] wd, rdata, got;
    logic [17:0] baddr;
    logic [15:0] bwd, brd;
    logic [1:0] bbe;
    logic [9:0] pc;
    int fails, cmp_count, i;
    typedef struct {
        logic [3:0] a;
        logic [15:0] d;
        logic [1:0] b;
        logic [15:0] e;
    } row_type;
    row_type rows[6] = '{'{`HP_SEL2_ADDR, 16'h1234, 2'h3, 16'h1234},
        '{`HP_SEL2_ADDR, 16'hab00, 2'h2, 16'hab34},
        '{`HP_SEL0_ADDR, 16'h0055, 2'h1, 16'h0055},
        '{`HP_MISC_ADDR, 16'h0004, 2'h3, 16'h0004},
        '{`HP_OUTDATA_ADDR, 16'h00a5, 2'h3, 16'h00a5},
        '{4'hc, 16'hffff, 2'h3, 16'h0000}};
    host_port_and_dma_master host_port_and_dma_master_inst (
        .clock_i(clock_i), .rst_i(rst_i), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
        .avs_byteenable_i(be), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wq), .mc_move_i(mv), .mc_dest_i(dst),
        .mc_scratch_addr_i(spa), .mc_alu_fn_i(fn), .bus_req_o(req),
        .selection_acknowledge_o(sack), .bus_master_o(mst),
        .bus_write_o(bwr), .bus_addr_o(baddr), .bus_wdata_o(bwd),
        .bus_be_o(bbe), .bus_grant_i(grant), .bus_done_i(done),
        .bus_rdata_i(brd), .run_o(run), .master_clear_o(mclr), .pc_o(pc));
    bus_arbiter_model bus_arbiter_model_inst (
        .clock_i(clock_i), .rst_i(rst_i), .bus_req_i(req),
        .bus_master_i(mst), .bus_addr_i(baddr), .bus_grant_o(grant),
        .bus_done_o(done), .bus_rdata_o(brd));
    task automatic chk(input string nm, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e) begin
            fails++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic acc(input logic w, input logic [3:0] a,
        input logic [15:0] d, input logic [1:0] b);
        int n;
        n = 0;
        @(posedge clock_i);
        addr <= a;
        wd <= {16'h0000, d};
        be <= {2'b00, b};
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clock_i);
            n++;
        end while (wq !== 1'b0 && n < 50);
        got = rdata;
        if (n >= 50) fails++;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic dma(input logic [15:0] ctl);
        int n;
        n = 0;
        acc(1, `HP_DMACTL_ADDR, ctl, 2'h3);
        while (mst !== 1'b1 && n < 20) begin
            @(posedge clock_i);
            n++;
        end
        if (n >= 20) fails++;
    endtask
    task automatic idle();
        for (int n = 0; n < 20; n++) begin
            acc(0, `HP_DMACTL_ADDR, 16'h0000, 2'h3);
            if (got[0] === 1'b0) break;
        end
        chk("dma request clear", got[0], 0);
    endtask
    task automatic summarize();
        if (fails == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    initial begin
        repeat (20000) @(posedge clock_i);
        fails++;
        summarize();
    end
    initial begin
        {rst_i, rd, wr, addr, wd, be} = {1'b1, 42'h0};
        {mv, dst, spa, fn} = 12'h000;
        repeat (2) @(posedge clock_i);
        chk("waitrequest", wq, 1);
        chk("pc", pc, 0);
        chk("master", mst, 0);
        rst_i <= 1'b0;
        acc(1, `HP_SEL0_ADDR, 16'h0000, 2'h2);
        foreach (rows[k]) begin
            acc(1, rows[k].a, rows[k].d, rows[k].b);
            acc(0, rows[k].a, 16'h0000, 2'h3);
            chk("register", got, {16'h0000, rows[k].e});
        end
        // Load then verify one control store word
        acc(1, `HP_SEL4_ADDR, 16'h001a, 2'h3);
        acc(1, `HP_SEL6_ADDR, 16'h0010, 2'h3);
        acc(1, `HP_SEL0_ADDR, 16'h0400, 2'h2);
        acc(1, `HP_SEL0_ADDR, 16'h2400, 2'h2);
        acc(1, `HP_SEL0_ADDR, 16'h0000, 2'h2);
        acc(1, `HP_SEL6_ADDR, 16'h7777, 2'h3);
        acc(1, `HP_SEL0_ADDR, 16'h0400, 2'h2);
        acc(0, `HP_SEL6_ADDR, 16'h0000, 2'h3);
        chk("control store", got, 32'h0010);
        acc(1, `HP_SEL0_ADDR, 16'h4000, 2'h2);
        repeat (2) @(posedge clock_i);
        chk("master clear", {mclr, run, 6'h0, pc}, 18'h20000);
        acc(1, `HP_SEL0_ADDR, 16'h8000, 2'h2);
        repeat (2) @(posedge clock_i);
        chk("run", {mclr, run}, 2'b01);
        // Microcode moves: scratch 0, +1 into both, sum, sum to RAM
        @(posedge clock_i);
        {mv, dst, spa, fn} <= {1'b1, 3'h6, 4'h1, 4'ha};
        @(posedge clock_i);
        {dst, fn} <= {3'h7, 4'h2};
        @(posedge clock_i);
        fn <= 4'h0;
        @(posedge clock_i);
        dst <= 3'h4;
        @(posedge clock_i);
        mv <= 1'b0;
        acc(0, `HP_SEL2_ADDR, 16'h0000, 2'h3);
        chk("move path", got, 32'hab04);
        acc(1, `HP_SEL0_ADDR, 16'h0000, 2'h2);
        // Byte writes to the even and the odd lane
        for (i = 0; i < 2; i++) begin
            acc(1, `HP_OUTBA_ADDR, 16'h0100 | 16'(i), 2'h3);
            dma(16'h000d);
            chk("byte addr", {bwr, baddr}, {1'b1, 18'h00100 | 18'(i)});
            chk("byte lanes", bbe, i ? 2'b10 : 2'b01);
            chk("byte data", i ? bwd[15:8] : bwd[7:0], 8'ha5);
            idle();
            chk("released", mst, 0);
        end
        // Word write, then word read, under held mastership
        dma(16'h000b);
        chk("word write", {bwr, bbe, bwd}, {3'b111, 16'h00a5});
        idle();
        chk("held", {mst, sack}, 2'b11);
        acc(1, `HP_INBA_ADDR, 16'h0200, 2'h3);
        dma(16'h0003);
        idle();
        acc(0, `HP_INDATA_ADDR, 16'h0000, 2'h3);
        chk("word read", got, 32'h585a);
        acc(1, `HP_DMACTL_ADDR, 16'h0000, 2'h3);
        repeat (3) @(posedge clock_i);
        chk("drop", {mst, sack}, 2'b00);
        // Reset again in mid-run
        rst_i <= 1'b1;
        @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        chk("reset", {wq, run, mst, sack, pc}, 14'h2000);
        summarize();
    end
endmodule
`default_nettype wire
